/* diag_cfg_pkg.sv */
// Constants and carrier types for the diagnostic configuration registers.
// Assumes a 25 MHz master clock and a 5-bit register address space.
`default_nettype none
package diag_cfg_pkg;
  // Register offsets
  localparam logic [4:0]  GEN_CFG2_ADDR      = 5'h0a;
  localparam logic [4:0]  DIAG_EN_ADDR       = 5'h10;
  // Reset values of the full 22-bit readback words
  localparam logic [21:0] GEN_CFG2_RESET     = 22'h0a_0200;
  localparam logic [21:0] DIAG_EN_RESET      = 22'h10_005d;
  // Common field positions
  localparam int          ALARM_BIT          = 21;
  localparam int          ADDR_LSB           = 16;
  localparam int          REG_WIDTH          = 22;
  // General configuration 2 fields
  localparam int          BCAST_LOAD_BIT     = 10;
  localparam int          FAULT_SEL_BIT      = 9;
  localparam int          GEN_CFG2_RW_MSB    = 14;
  // Diagnostic enable fields
  localparam int          LATCH_MON_BIT      = 6;
  localparam int          INV_CHECK_BIT      = 4;
  localparam int          CAL_CRC_BIT        = 3;
  localparam int          FREQ_MON_BIT       = 2;
  localparam int          LINK_CRC_BIT       = 0;
  localparam int          DIAG_EN_RW_MSB     = 6;
  // Converter code width
  localparam int          CODE_WIDTH         = 14;
  // Fault persistence times and derived cycle counts
  localparam int          CLK_FREQ_KHZ       = 25000;
  localparam int          FAULT_LONG_US      = 25000;
  localparam int          FAULT_SHORT_US     = 6500;
  localparam int          FAULT_LONG_CYCLES  = FAULT_LONG_US * CLK_FREQ_KHZ / 1000;
  localparam int          FAULT_SHORT_CYCLES = FAULT_SHORT_US * CLK_FREQ_KHZ / 1000;
  localparam int          TIMER_WIDTH        = 20;

  // Register write request from the serial host port
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] data;
  } reg_wr_s;

  // Internal, latched and inverse converter codes for the latch monitor and inverse check
  typedef struct packed {
    logic [CODE_WIDTH-1:0] internal_code;
    logic [CODE_WIDTH-1:0] latched_code;
    logic [CODE_WIDTH-1:0] inverse_code;
  } code_set_s;
endpackage : diag_cfg_pkg
`default_nettype wire

/* diag_config_registers.sv */
// Diagnostic configuration registers: general config 2 and digital check enables.
// Assumes the serial host port decodes frames into one-cycle write and read strobes.
`timescale 1ns/1ps
`default_nettype none
module diag_config_registers #(
  parameter int FAULT_LONG_CYCLES  = diag_cfg_pkg::FAULT_LONG_CYCLES,  // 25 ms count
  parameter int FAULT_SHORT_CYCLES = diag_cfg_pkg::FAULT_SHORT_CYCLES  // 6.5 ms count
) (
  input  wire logic                      clk_i,             // Master clock
  input  wire logic                      arst_n_i,          // Async reset, low
  input  wire diag_cfg_pkg::reg_wr_s     reg_wr_i,          // Register write request
  input  wire logic                      rd_i,              // Read strobe
  input  wire logic [4:0]                rd_addr_i,         // Read address
  input  wire logic                      alarm_pin_i,       // Alarm pin level
  input  wire logic                      sw_load_cmd_i,     // Software load command
  input  wire logic                      addr_match_i,      // Address pins match
  input  wire logic                      fault_raw_i,       // Raw output fault
  input  wire diag_cfg_pkg::code_set_s   codes_i,           // Converter codes
  input  wire logic                      cal_refresh_i,     // Cal memory refreshed
  input  wire logic                      err_clear_i,       // Clear error flags
  output logic [21:0]                    rdata_o,           // Read data
  output logic                           rvalid_o,          // Read data valid
  output logic                           load_pulse_o,      // Load converter
  output logic                           fault_filtered_o,  // Persisted fault
  output logic                           latch_monitor_error_o, // Latch mismatch
  output logic                           inverse_error_o,   // Inverse mismatch
  output logic                           cal_crc_start_o,   // Start cal CRC
  output logic                           clock_frequency_monitor_enable_o,     // Freq monitor on
  output logic                           link_crc_en_o      // Link CRC on
);
  logic [diag_cfg_pkg::GEN_CFG2_RW_MSB:0] gen_cfg2;
  logic [diag_cfg_pkg::DIAG_EN_RW_MSB:0]  diag_en;
  logic [diag_cfg_pkg::TIMER_WIDTH-1:0]   fault_limit;
  logic                                   filt_fault;

  // Address decode shared by write and read
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // General configuration 2 writable field
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gen_cfg2 <= diag_cfg_pkg::GEN_CFG2_RESET[diag_cfg_pkg::GEN_CFG2_RW_MSB:0];
    end else if (reg_wr_i.wr && hit(reg_wr_i.addr, diag_cfg_pkg::GEN_CFG2_ADDR)) begin
      gen_cfg2 <= reg_wr_i.data[diag_cfg_pkg::GEN_CFG2_RW_MSB:0];
    end
  end

  // Diagnostic enable writable field
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_en <= diag_cfg_pkg::DIAG_EN_RESET[diag_cfg_pkg::DIAG_EN_RW_MSB:0];
    end else if (reg_wr_i.wr && hit(reg_wr_i.addr, diag_cfg_pkg::DIAG_EN_ADDR)) begin
      diag_en <= reg_wr_i.data[diag_cfg_pkg::DIAG_EN_RW_MSB:0];
    end
  end

  // Registered readback with live alarm level and own address
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        if (hit(rd_addr_i, diag_cfg_pkg::GEN_CFG2_ADDR)) begin
          rdata_o <= {alarm_pin_i, diag_cfg_pkg::GEN_CFG2_ADDR, 1'b0, gen_cfg2};
        end else if (hit(rd_addr_i, diag_cfg_pkg::DIAG_EN_ADDR)) begin
          rdata_o <= {alarm_pin_i, diag_cfg_pkg::DIAG_EN_ADDR, 9'h000, diag_en};
        end else begin
          rdata_o <= {alarm_pin_i, rd_addr_i, 16'h0000};
        end
      end
    end
  end

  // Broadcast software load ignores the address pins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_pulse_o <= 1'b0;
    end else begin
      load_pulse_o <= sw_load_cmd_i && (gen_cfg2[diag_cfg_pkg::BCAST_LOAD_BIT] || addr_match_i);
    end
  end

  // Fault persistence length select
  assign fault_limit = gen_cfg2[diag_cfg_pkg::FAULT_SEL_BIT]
                     ? FAULT_SHORT_CYCLES[diag_cfg_pkg::TIMER_WIDTH-1:0]
                     : FAULT_LONG_CYCLES[diag_cfg_pkg::TIMER_WIDTH-1:0];

  fault_persist_filter u_fault_filter (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .limit_i    (fault_limit),
    .raw_i      (fault_raw_i),
    .filtered_o (filt_fault)
  );

  // Output register for the persisted fault
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_filtered_o <= 1'b0;
    end else begin
      fault_filtered_o <= filt_fault;
    end
  end

  // Sticky check flags, set wins over clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_monitor_error_o <= 1'b0;
      inverse_error_o       <= 1'b0;
    end else begin
      if (diag_en[diag_cfg_pkg::LATCH_MON_BIT] && (codes_i.latched_code != codes_i.internal_code)) begin
        latch_monitor_error_o <= 1'b1;
      end else if (err_clear_i) begin
        latch_monitor_error_o <= 1'b0;
      end
      if (diag_en[diag_cfg_pkg::INV_CHECK_BIT] && (codes_i.latched_code != ~codes_i.inverse_code)) begin
        inverse_error_o <= 1'b1;
      end else if (err_clear_i) begin
        inverse_error_o <= 1'b0;
      end
    end
  end

  // Engine enables and calibration CRC trigger
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_crc_start_o <= 1'b0;
      clock_frequency_monitor_enable_o   <= 1'b1;
      link_crc_en_o   <= 1'b1;
    end else begin
      cal_crc_start_o <= cal_refresh_i && diag_en[diag_cfg_pkg::CAL_CRC_BIT];
      clock_frequency_monitor_enable_o   <= diag_en[diag_cfg_pkg::FREQ_MON_BIT];
      link_crc_en_o   <= diag_en[diag_cfg_pkg::LINK_CRC_BIT];
    end
  end

  // Assertions
  property p_bcast_load;
    @(posedge clk_i) disable iff (!arst_n_i)
    sw_load_cmd_i && !addr_match_i && gen_cfg2[diag_cfg_pkg::BCAST_LOAD_BIT] |=> load_pulse_o;
  endproperty
  a_bcast_load: assert property (p_bcast_load) else $error("broadcast load missed");

  property p_addr_load;
    @(posedge clk_i) disable iff (!arst_n_i)
    sw_load_cmd_i && !addr_match_i && !gen_cfg2[diag_cfg_pkg::BCAST_LOAD_BIT] |=> !load_pulse_o;
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("load without address match");

  property p_fault_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    $changed(filt_fault) |-> $past(fault_raw_i) == filt_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault changed against raw");

  property p_latch_err;
    @(posedge clk_i) disable iff (!arst_n_i)
    diag_en[diag_cfg_pkg::LATCH_MON_BIT] && (codes_i.latched_code != codes_i.internal_code)
      |=> latch_monitor_error_o [*1];
  endproperty
  a_latch_err: assert property (p_latch_err) else $error("latch mismatch not flagged");

  property p_inv_err;
    @(posedge clk_i) disable iff (!arst_n_i)
    !inverse_error_o && !diag_en[diag_cfg_pkg::INV_CHECK_BIT] |=> !inverse_error_o;
  endproperty
  a_inv_err: assert property (p_inv_err) else $error("inverse flag while disabled");

  property p_cal_crc;
    @(posedge clk_i) disable iff (!arst_n_i)
    cal_refresh_i ##0 diag_en[diag_cfg_pkg::CAL_CRC_BIT] |=> cal_crc_start_o;
  endproperty
  a_cal_crc: assert property (p_cal_crc) else $error("cal CRC not started");

  property p_freq_mon;
    @(posedge clk_i) disable iff (!arst_n_i)
    reg_wr_i.wr && reg_wr_i.addr == diag_cfg_pkg::DIAG_EN_ADDR
      |=> ##1 clock_frequency_monitor_enable_o == $past(reg_wr_i.data[diag_cfg_pkg::FREQ_MON_BIT], 2);
  endproperty
  a_freq_mon: assert property (p_freq_mon) else $error("freq monitor enable wrong");

  property p_link_crc;
    @(posedge clk_i) disable iff (!arst_n_i)
    reg_wr_i.wr && reg_wr_i.addr == diag_cfg_pkg::DIAG_EN_ADDR
      |=> ##1 link_crc_en_o == $past(reg_wr_i.data[diag_cfg_pkg::LINK_CRC_BIT], 2);
  endproperty
  a_link_crc: assert property (p_link_crc) else $error("link CRC enable wrong");

  property p_alarm_bit;
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_i |=> rvalid_o && rdata_o[diag_cfg_pkg::ALARM_BIT] == $past(alarm_pin_i);
  endproperty
  a_alarm_bit: assert property (p_alarm_bit) else $error("alarm bit not live");

  property p_diag_addr;
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_i && rd_addr_i == diag_cfg_pkg::DIAG_EN_ADDR
      |=> rdata_o[20:16] == diag_cfg_pkg::DIAG_EN_ADDR && rdata_o[15:7] == 9'h000;
  endproperty
  a_diag_addr: assert property (p_diag_addr) else $error("diag register readback wrong");

  c_bcast: cover property (@(posedge clk_i) sw_load_cmd_i && !addr_match_i ##1 load_pulse_o);
  c_fault: cover property (@(posedge clk_i) $rose(fault_filtered_o));
  c_latch: cover property (@(posedge clk_i) $rose(latch_monitor_error_o));
  c_read:  cover property (@(posedge clk_i) rd_i && rd_addr_i == diag_cfg_pkg::DIAG_EN_ADDR);
endmodule : diag_config_registers
`default_nettype wire

/* fault_persist_filter.sv */
// Persistence filter for the analog output fault indication.
// Assumes a raw fault level synchronous to clk_i and a limit held steady.
`timescale 1ns/1ps
`default_nettype none
module fault_persist_filter (
  input  wire logic                                 clk_i,      // Master clock
  input  wire logic                                 arst_n_i,   // Async reset, low
  input  wire logic [diag_cfg_pkg::TIMER_WIDTH-1:0] limit_i,    // Cycles to persist
  input  wire logic                                 raw_i,      // Raw fault level
  output logic                                      filtered_o  // Filtered fault level
);
  logic [diag_cfg_pkg::TIMER_WIDTH-1:0] count;

  // Count while raw differs from filtered, restart on agreement
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count      <= '0;
      filtered_o <= 1'b0;
    end else if (raw_i == filtered_o) begin
      count <= '0;
    end else if (count + 1'b1 >= limit_i) begin
      count      <= '0;
      filtered_o <= raw_i;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : fault_persist_filter
`default_nettype wire

/* tb.sv */
// Self-checking bench for the diagnostic configuration registers.
// Assumes short fault persistence counts so that the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LONG_C  = 20;
  localparam int SHORT_C = 6;
  localparam diag_cfg_pkg::code_set_s GOOD = '{14'h0155, 14'h0155, ~14'h0155};
  typedef struct {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        alarm;
    logic [15:0] field;
  } row_s;
  row_s rows [5] = '{
    '{5'h0a, 16'h0400, 1'b1, 16'h0400},
    '{5'h10, 16'h005d, 1'b0, 16'h005d},
    '{5'h0a, 16'h0600, 1'b0, 16'h0600},
    '{5'h05, 16'h1234, 1'b1, 16'h0000},
    '{5'h10, 16'h0000, 1'b1, 16'h0000}};
  logic                    clk_i = 1'b0;
  logic                    arst_n_i = 1'b0;
  diag_cfg_pkg::reg_wr_s   reg_wr_i = '0;
  logic                    rd_i = 1'b0;
  logic [4:0]              rd_addr_i = 5'h00;
  logic                    alarm_pin_i = 1'b0;
  logic                    sw_load_cmd_i = 1'b0;
  logic                    addr_match_i = 1'b0;
  logic                    fault_raw_i = 1'b0;
  diag_cfg_pkg::code_set_s codes_i = GOOD;
  logic                    cal_refresh_i = 1'b0;
  logic                    err_clear_i = 1'b0;
  logic [21:0]             rdata_o;
  logic                    rvalid_o, load_pulse_o, fault_filtered_o, latch_monitor_error_o;
  logic                    inverse_error_o, cal_crc_start_o, clock_frequency_monitor_enable_o, link_crc_en_o;
  int                      error_cnt = 0;
  int                      check_count = 0;
  int                      cycle_cnt = 0;

  diag_config_registers #(.FAULT_LONG_CYCLES(LONG_C), .FAULT_SHORT_CYCLES(SHORT_C)) u_diag_config_registers (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .rd_i(rd_i), .rd_addr_i(rd_addr_i),
    .alarm_pin_i(alarm_pin_i), .sw_load_cmd_i(sw_load_cmd_i), .addr_match_i(addr_match_i),
    .fault_raw_i(fault_raw_i), .codes_i(codes_i), .cal_refresh_i(cal_refresh_i), .err_clear_i(err_clear_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .load_pulse_o(load_pulse_o), .fault_filtered_o(fault_filtered_o),
    .latch_monitor_error_o(latch_monitor_error_o), .inverse_error_o(inverse_error_o),
    .cal_crc_start_o(cal_crc_start_o), .clock_frequency_monitor_enable_o(clock_frequency_monitor_enable_o), .link_crc_en_o(link_crc_en_o));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic do_reset();
    @(posedge clk_i) arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
  endtask : do_reset

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i) reg_wr_i <= '{1'b1, a, d};
    @(posedge clk_i) reg_wr_i <= '0;
  endtask : wr

  // Read and compare one whole word
  task automatic rd(input logic [4:0] a, input logic [21:0] exp);
    @(posedge clk_i);
    rd_i      <= 1'b1;
    rd_addr_i <= a;
    @(posedge clk_i) rd_i <= 1'b0;
    #1;
    check(rvalid_o, 1'b1);
    check(rdata_o, exp);
  endtask : rd

  // One-cycle strobe: 0 load, 1 cal refresh, 2 error clear
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: sw_load_cmd_i <= 1'b1;
      1: cal_refresh_i <= 1'b1;
      default: err_clear_i <= 1'b1;
    endcase
    @(posedge clk_i);
    sw_load_cmd_i <= 1'b0;
    cal_refresh_i <= 1'b0;
    err_clear_i   <= 1'b0;
    #1;
  endtask : pulse

  task automatic code_glitch(input diag_cfg_pkg::code_set_s c);
    @(posedge clk_i) codes_i <= c;
    @(posedge clk_i) codes_i <= GOOD;
    #1;
  endtask : code_glitch

  // Hold a fault level and count edges until the filtered output follows
  task automatic fault_wait(input logic lvl, input int lim);
    int n;
    n = 0;
    @(posedge clk_i) fault_raw_i <= lvl;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (fault_filtered_o !== lvl && n < lim + 10);
    check(n >= lim && n <= lim + 2, 1'b1);
  endtask : fault_wait

  initial begin
    do_reset();
    // Ordinary write then read rows
    foreach (rows[i]) begin
      @(posedge clk_i) alarm_pin_i <= rows[i].alarm;
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, {rows[i].alarm, rows[i].addr, rows[i].field});
    end
    // All diagnostic enables now clear
    check(clock_frequency_monitor_enable_o, 1'b0);
    check(link_crc_en_o, 1'b0);
    code_glitch('{14'h0155, 14'h0156, ~14'h0155});
    check(latch_monitor_error_o, 1'b0);
    check(inverse_error_o, 1'b0);
    pulse(1);
    check(cal_crc_start_o, 1'b0);
    // Second reset mid-run restores defaults
    do_reset();
    check(clock_frequency_monitor_enable_o, 1'b1);
    check(link_crc_en_o, 1'b1);
    rd(diag_cfg_pkg::DIAG_EN_ADDR, {1'b1, 5'h10, 16'h005d});
    rd(diag_cfg_pkg::GEN_CFG2_ADDR, {1'b1, 5'h0a, 16'h0200});
    // Software load with and without broadcast
    pulse(0);
    check(load_pulse_o, 1'b0);
    @(posedge clk_i) addr_match_i <= 1'b1;
    pulse(0);
    check(load_pulse_o, 1'b1);
    @(posedge clk_i) addr_match_i <= 1'b0;
    wr(diag_cfg_pkg::GEN_CFG2_ADDR, 16'h0600);
    pulse(0);
    check(load_pulse_o, 1'b1);
    // Latch monitor and inverse check flags, then clear
    code_glitch('{14'h0155, 14'h0156, ~14'h0156});
    check(latch_monitor_error_o, 1'b1);
    check(inverse_error_o, 1'b0);
    code_glitch('{14'h0155, 14'h0155, 14'h0000});
    check(inverse_error_o, 1'b1);
    pulse(2);
    check(latch_monitor_error_o, 1'b0);
    check(inverse_error_o, 1'b0);
    // Mismatch and clear in one cycle: set wins
    @(posedge clk_i) begin
      codes_i     <= '{14'h0155, 14'h0156, ~14'h0156};
      err_clear_i <= 1'b1;
    end
    @(posedge clk_i) begin
      codes_i     <= GOOD;
      err_clear_i <= 1'b0;
    end
    #1;
    check(latch_monitor_error_o, 1'b1);
    pulse(2);
    check(latch_monitor_error_o, 1'b0);
    pulse(1);
    check(cal_crc_start_o, 1'b1);
    // Fault shorter than the limit is dropped
    @(posedge clk_i) fault_raw_i <= 1'b1;
    repeat (SHORT_C - 1) @(posedge clk_i);
    fault_raw_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check(fault_filtered_o, 1'b0);
    fault_wait(1'b1, SHORT_C);
    wr(diag_cfg_pkg::GEN_CFG2_ADDR, 16'h0000);
    fault_wait(1'b0, LONG_C);
    complete_run();
  end
endmodule : tb
`default_nettype wire
